// ---- bench/afc_master.sv ----
// bus master model that frames register reads and writes on the link
`timescale 1ns/10ps
`default_nettype none
module afc_master (
  output logic      scl_o,
  output logic      sda_o,
  input  wire logic sda_i
);
  localparam int Q = 40;  // quarter of the 160 ns link bit
  logic [7:0] rdat [4];
  logic       s;
  // both lines released between frames, so the link clock stands high
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // data changes only while the clock is low, sampled mid high
  task bit_io(input logic b, output logic r);
    sda_o = b;
    #Q scl_o = 1'b1;
    #Q r = sda_i;
    #Q scl_o = 1'b0;
    #Q;
  endtask : bit_io
  // also serves as the repeated start of a read
  task start();
    sda_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b0;
    #Q scl_o = 1'b0;
    #Q;
  endtask : start
  task stop();
    sda_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_o = 1'b1;
    #Q;
  endtask : stop
  task send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask : send
  // a read probe clocks one byte out and nacks it, so the slave lets go
  task probe(input logic [7:0] a, output logic ack);
    start();
    send(a, ack);
    if (a[0] && ack) begin
      for (int i = 7; i >= 0; i--) bit_io(1'b1, s);
      bit_io(1'b1, s);
    end
    stop();
  endtask : probe
  // reserved control bits always go out as zero
  task wr_reg(input logic [7:0] p, input logic [7:0] v, output logic ok);
    logic a0, a1, a2;
    start();
    send(8'hd8, a0);
    send(p, a1);
    send((p == 8'h03) ? (v & 8'hf9) : v, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask : wr_reg
  // every byte acked but the last, which gets a nack before stop
  task rd_regs(input logic [7:0] p, input int n, output logic ok);
    logic a0, a1, a2;
    start();
    send(8'hd8, a0);
    send(p, a1);
    start();
    send(8'hd9, a2);
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) bit_io(1'b1, rdat[k][i]);
      bit_io(k == n - 1, s);
    end
    stop();
    ok = a0 & a1 & a2;
  endtask : rd_regs
endmodule : afc_master
`default_nettype wire

// ---- bench/amp_fault_status_control_regs_tb.sv ----
// self-checking bench for the amplifier register bank
`timescale 1ns/10ps
`default_nettype none
module amp_fault_status_control_regs_tb;
  logic       clk_i = 1'b0, nrst_i = 1'b0, standby_n_i = 1'b0;
  logic       mute_i = 1'b0, diag_done_i = 1'b0, rerun_seen = 1'b0;
  logic [5:0] fault_ev_i = 6'h00;
  logic [3:0] diag_ev_i = 4'h0;
  wire        scl, m_sda, sda_w, sda_oe, sda_lvl, fault_lvl, fault_oe;
  wire        float_o, rerun_diag_o, freq_500k_o;
  wire  [1:0] mode_o, gain_o;
  wire  [2:0] limit_o;
  logic       ok;
  int         miscompares = 0, samples_checked = 0, cycles = 0;
  // wired-and data line with pull-up: either side may pull low
  assign sda_w = m_sda & ~sda_oe;
  always #10 clk_i = ~clk_i;
  afc_regs #(.READY_CYCLES(20)) i_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .en_i(1'b1), .scl_i(scl),
    .sda_i(sda_w), .standby_n_i(standby_n_i), .mute_i(mute_i),
    .fault_ev_i(fault_ev_i), .diag_ev_i(diag_ev_i),
    .diag_done_i(diag_done_i), .sda_o(sda_lvl), .sda_oe_o(sda_oe),
    .fault_n_o(fault_lvl), .fault_n_oe_o(fault_oe), .mode_o(mode_o),
    .float_o(float_o), .rerun_diag_o(rerun_diag_o), .gain_o(gain_o),
    .limit_o(limit_o), .freq_500k_o(freq_500k_o));
  afc_master i_master (.scl_o(scl), .sda_o(m_sda), .sda_i(sda_w));
  // rerun is a one-cycle pulse, so keep a sticky copy
  always @(posedge clk_i) if (rerun_diag_o === 1'b1) rerun_seen <= 1'b1;
  // hang guard, well above the roughly 12k cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      finish_test();
    end
  end
  task finish_test();
    if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  task check(input logic [7:0] got, input logic [7:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      $display("wrong value at %0t: %s", $time, m);
      miscompares++;
    end
  endtask : check
  task settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : settle
  task rd1(input logic [7:0] p, input logic [7:0] exp);
    i_master.rd_regs(p, 1, ok);
    check(i_master.rdat[0], exp, "register read");
  endtask : rd1
  task pulse_done();
    rerun_seen = 1'b0;
    diag_done_i = 1'b1;
    settle(1);
    diag_done_i = 1'b0;
    settle(5);
  endtask : pulse_done
  // standby: outputs float, bus silent, control at defaults
  task t_standby();
    check({6'h0, mode_o}, 8'h00, "standby mode");
    check({7'h0, float_o}, 8'h01, "standby float");
    check({gain_o, limit_o, 2'b00, freq_500k_o}, 8'h78, "ctl pins");
    check({6'h0, sda_lvl, fault_lvl}, 8'h00, "pin low levels");
    i_master.probe(8'hd8, ok);
    check({7'h0, ok}, 8'h00, "ack in standby");
  endtask : t_standby
  // diagnostics after release, sequential read, shorted and open load
  task t_diag();
    standby_n_i = 1'b1;
    settle(30);
    check({6'h0, mode_o, float_o}, 8'h02, "diag mode");
    i_master.rd_regs(8'h01, 3, ok);
    check({7'h0, ok}, 8'h01, "ack once ready");
    check(i_master.rdat[0], 8'h00, "fault reset");
    check(i_master.rdat[1], 8'h20, "diag status");
    check(i_master.rdat[2], 8'h78, "control reset");
    diag_ev_i = 4'h3;
    settle(5);
    rd1(8'h02, 8'h23);
    diag_ev_i = 4'h8;
    settle(5);
    rd1(8'h02, 8'h28);
    pulse_done();
    check({6'h0, rerun_seen, float_o}, 8'h03, "shorted rerun");
    diag_ev_i = 4'h4;
    settle(5);
    pulse_done();
    check({6'h0, rerun_seen, float_o}, 8'h00, "open no action");
    check({6'h0, mode_o}, 8'h03, "play mode");
    rd1(8'h02, 8'h84);
    diag_ev_i = 4'h0;
    settle(5);
    rd1(8'h02, 8'h80);
  endtask : t_diag
  // every gain, limit and frequency code written and read back
  task t_control();
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {i[1:0], i[2:0], 2'b00, i[0]};
      i_master.wr_reg(8'h03, v, ok);
      settle(3);
      check({gain_o, limit_o, 2'b00, freq_500k_o}, v, "ctl");
      rd1(8'h03, v);
    end
    i_master.wr_reg(8'h01, 8'hff, ok);
    rd1(8'h01, 8'h00);
    i_master.wr_reg(8'h05, 8'hff, ok);
    rd1(8'h05, 8'h00);
  endtask : t_control
  task t_addr();
    i_master.probe(8'hda, ok);
    check({7'h0, ok}, 8'h00, "foreign address");
    i_master.probe(8'hd9, ok);
    check({7'h0, ok}, 8'h01, "own read address");
  endtask : t_addr
  task t_mute();
    mute_i = 1'b1;
    settle(5);
    check({5'h0, mode_o, float_o}, 8'h05, "mute floats");
    check({7'h0, fault_oe}, 8'h00, "mute no fault pin");
    rd1(8'h02, 8'h40);
    mute_i = 1'b0;
    settle(5);
    check({5'h0, mode_o, float_o}, 8'h06, "back to play");
  endtask : t_mute
  // each cause latches, survives its removal, clears on read
  task t_faults();
    for (int k = 0; k < 6; k++) begin
      fault_ev_i = 6'h01 << k;
      settle(5);
      if (k > 0) begin
        check({5'h0, fault_oe, mode_o}, 8'h06, "fault pin");
      end
      if (k == 5) rd1(8'h02, 8'h10);
      fault_ev_i = 6'h00;
      settle(5);
      rd1(8'h01, 8'h04 << k);
      rd1(8'h01, 8'h00);
    end
  endtask : t_faults
  // standby puts the control register back to its default
  task t_reenter();
    i_master.wr_reg(8'h03, 8'h00, ok);
    standby_n_i = 1'b0;
    settle(5);
    check({gain_o, limit_o, 2'b00, freq_500k_o}, 8'h78, "ctl cleared");
    check({5'h0, mode_o, float_o}, 8'h01, "standby again");
  endtask : t_reenter
  initial begin
    settle(2);
    nrst_i = 1'b1;
    settle(2);
    t_standby();
    t_diag();
    t_control();
    t_addr();
    t_mute();
    t_faults();
    t_reenter();
    finish_test();
  end
endmodule : amp_fault_status_control_regs_tb
`default_nettype wire

// ---- design/afc_i2c.sv ----
// byte-level bus slave: address match, pointer, reads and writes
`timescale 1ns/10ps
`default_nettype none
module afc_i2c (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       en_i,
  input  wire logic       active_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [7:0] rdata_i,
  output logic            sda_oe_o,
  output logic      [7:0] ptr_o,
  output logic            wr_o,
  output logic      [7:0] wdata_o,
  output logic            rd_o
);
  typedef enum logic [2:0] {
    AFC_ST_IDLE = 3'b000,
    AFC_ST_ADDR = 3'b001,
    AFC_ST_AACK = 3'b010,
    AFC_ST_RX   = 3'b011,
    AFC_ST_RACK = 3'b100,
    AFC_ST_TX   = 3'b101,
    AFC_ST_TACK = 3'b110
  } afc_i2c_st_t;
  afc_i2c_st_t st_q, st_d;
  logic [7:0] sh_q, sh_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] ptr_q, ptr_d;
  logic       first_q, first_d, rdir_q, rdir_d;
  logic       oe_q, oe_d, wr_q, wr_d, rd_q, rd_d;
  logic       scl_p_q, sda_p_q;
  logic       rise, fall, start_c, stop_c;
  assign rise    = scl_i & ~scl_p_q;
  assign fall    = ~scl_i & scl_p_q;
  assign start_c = scl_i & scl_p_q & sda_p_q & ~sda_i;
  assign stop_c  = scl_i & scl_p_q & ~sda_p_q & sda_i;
  // bit sequencer; scl edges are found from the sampled pin
  always_comb begin
    st_d = st_q; sh_d = sh_q; cnt_d = cnt_q; ptr_d = ptr_q;
    first_d = first_q; rdir_d = rdir_q; oe_d = oe_q; wr_d = 1'b0; rd_d = 1'b0;
    if (!active_i || stop_c) begin
      st_d = AFC_ST_IDLE; oe_d = 1'b0;
    end else if (start_c) begin
      st_d = AFC_ST_ADDR; cnt_d = 4'h0; oe_d = 1'b0;
    end else begin
      unique case (st_q)
        AFC_ST_IDLE: ;
        AFC_ST_ADDR, AFC_ST_RX: begin
          if (rise) begin
            sh_d = {sh_q[6:0], sda_i};
            cnt_d = cnt_q + 4'h1;
          end
          if (fall && cnt_q == 4'h8) begin
            if (st_q == AFC_ST_ADDR) begin
              // only the fixed address answers
              if (sh_q[7:1] == afc_pkg::DEV_ADDR) begin
                st_d = AFC_ST_AACK; oe_d = 1'b1;
                rdir_d = sh_q[0]; first_d = 1'b1;
              end else st_d = AFC_ST_IDLE;
            end else begin
              st_d = AFC_ST_RACK; oe_d = 1'b1;
              if (first_q) ptr_d = sh_q;
              else wr_d = 1'b1; // data byte itself is captured in wd_q
            end
          end
        end
        AFC_ST_AACK, AFC_ST_RACK: if (fall) begin
          cnt_d = 4'h0;
          if (st_q == AFC_ST_AACK && rdir_q) begin
            st_d = AFC_ST_TX; sh_d = rdata_i; rd_d = 1'b1;
            oe_d = ~rdata_i[7];
          end else begin
            if (st_q == AFC_ST_RACK) begin
              if (!first_q) ptr_d = ptr_q + 8'h01; // write pointer steps too
              first_d = 1'b0;
            end
            st_d = AFC_ST_RX; oe_d = 1'b0;
          end
        end
        AFC_ST_TX: begin
          if (fall) begin
            cnt_d = cnt_q + 4'h1;
            sh_d = {sh_q[6:0], 1'b0};
            if (cnt_q == 4'h7) begin
              st_d = AFC_ST_TACK; oe_d = 1'b0;
            end else oe_d = ~sh_q[6];
          end
        end
        AFC_ST_TACK: if (rise) begin
          if (sda_i) st_d = AFC_ST_IDLE; // nack ends the read
          else begin
            // pointer steps after each byte sent that the master acks
            ptr_d = ptr_q + 8'h01;
            st_d = AFC_ST_AACK;
          end
        end
        default: st_d = AFC_ST_IDLE;
      endcase
    end
  end
  logic [7:0] wd_q;
  // captured data byte of a write
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) wd_q <= 8'h00;
    else if (en_i && st_q == AFC_ST_RX && fall && cnt_q == 4'h8) wd_q <= sh_q;
  end
  // state, strobe and sampled pin registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= AFC_ST_IDLE; sh_q <= 8'h00; cnt_q <= 4'h0; ptr_q <= 8'h00;
      first_q <= 1'b0; rdir_q <= 1'b0; oe_q <= 1'b0; wr_q <= 1'b0;
      rd_q <= 1'b0; scl_p_q <= 1'b1; sda_p_q <= 1'b1;
    end else if (en_i) begin
      st_q <= st_d; sh_q <= sh_d; cnt_q <= cnt_d; ptr_q <= ptr_d;
      first_q <= first_d; rdir_q <= rdir_d; oe_q <= oe_d; wr_q <= wr_d;
      rd_q <= rd_d; scl_p_q <= scl_i; sda_p_q <= sda_i;
    end
  end
  assign sda_oe_o = oe_q;
  assign ptr_o    = ptr_q;
  assign wr_o     = wr_q;
  assign wdata_o  = wd_q;
  assign rd_o     = rd_q;
endmodule : afc_i2c
`default_nettype wire

// ---- design/afc_pkg.sv ----
// shared constants for the amplifier fault, status and control register bank
package afc_pkg;
  localparam logic [6:0] DEV_ADDR     = 7'h6c;  // write byte d8, read byte d9
  localparam logic [7:0] OFS_FAULT    = 8'h01;
  localparam logic [7:0] OFS_STATUS   = 8'h02;
  localparam logic [7:0] OFS_CONTROL  = 8'h03;
  localparam logic [7:0] FAULT_RST    = 8'h00;
  localparam logic [7:0] STATUS_RST   = 8'h00;
  localparam logic [7:0] CONTROL_RST  = 8'h78;
  // fault register bit positions
  localparam int FB_DIAG = 2;
  localparam int FB_OC   = 3;
  localparam int FB_UV   = 4;
  localparam int FB_OV   = 5;
  localparam int FB_DC   = 6;
  localparam int FB_OT   = 7;
  // status register bit positions
  localparam int SB_SHORT_SUP  = 0;
  localparam int SB_SHORT_GND  = 1;
  localparam int SB_OPEN       = 2;
  localparam int SB_SHORT_LOAD = 3;
  localparam int SB_FAULT      = 4;
  localparam int SB_DIAG       = 5;
  localparam int SB_MUTE       = 6;
  localparam int SB_PLAY       = 7;
  // control register fields
  localparam int CB_FREQ   = 0;
  localparam int CB_LIM_LO = 3;
  localparam int CB_GAIN_LO = 6;
  localparam logic [2:0] LIM_OFF = 3'h7;
  // bus ready delay after standby release
  localparam int  CLK_HZ       = 50_000_000;
  localparam int  READY_US     = 1000;
  localparam int  READY_CYCLES = READY_US * (CLK_HZ / 1_000_000);
  typedef enum logic [1:0] {
    AFC_MODE_STANDBY = 2'b00,
    AFC_MODE_DIAG    = 2'b01,
    AFC_MODE_FAULT   = 2'b10,
    AFC_MODE_PLAY    = 2'b11
  } afc_mode_t;
endpackage : afc_pkg

// ---- design/afc_regs.sv ----
// amplifier fault, status and control register bank with mode logic
`timescale 1ns/10ps
`default_nettype none
module afc_regs #(
  parameter int READY_CYCLES = afc_pkg::READY_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       en_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       standby_n_i,
  input  wire logic       mute_i,
  input  wire logic [5:0] fault_ev_i,
  input  wire logic [3:0] diag_ev_i,
  input  wire logic       diag_done_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic            fault_n_o,
  output logic            fault_n_oe_o,
  output logic      [1:0] mode_o,
  output logic            float_o,
  output logic            rerun_diag_o,
  output logic      [1:0] gain_o,
  output logic      [2:0] limit_o,
  output logic            freq_500k_o
);
  logic [13:0] pins_s;
  logic        scl_s, sda_s, stby_s, mute_s;
  logic [5:0]  fev_s;
  logic [3:0]  dev_s;
  logic        ddone_s;
  afc_sync #(.W(14)) u_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .en_i   (en_i),
    .d_i    ({scl_i, sda_i, standby_n_i, mute_i, fault_ev_i, diag_ev_i}),
    .q_o    (pins_s)
  );
  assign {scl_s, sda_s, stby_s, mute_s, fev_s, dev_s} = pins_s;
  assign ddone_s = diag_done_i; // same clock domain

  // ready counter after standby release
  logic [19:0] rdy_cnt_q, rdy_cnt_d;
  logic        ready;
  always_comb begin
    rdy_cnt_d = rdy_cnt_q;
    if (!stby_s) rdy_cnt_d = 20'h00000;
    else if (rdy_cnt_q != 20'(READY_CYCLES)) rdy_cnt_d = rdy_cnt_q + 20'h1;
  end
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) rdy_cnt_q <= 20'h00000;
    else if (en_i) rdy_cnt_q <= rdy_cnt_d;
  end
  assign ready = stby_s && rdy_cnt_q == 20'(READY_CYCLES);

  // bus slave, held off in standby and until ready
  logic [7:0] ptr, wdata, rdata;
  logic       wr, rd, oe_bus;
  afc_i2c u_i2c (
    .clk_i    (clk_i),
    .nrst_i   (nrst_i),
    .en_i     (en_i),
    .active_i (ready),
    .scl_i    (scl_s),
    .sda_i    (sda_s),
    .rdata_i  (rdata),
    .sda_oe_o (oe_bus),
    .ptr_o    (ptr),
    .wr_o     (wr),
    .wdata_o  (wdata),
    .rd_o     (rd)
  );

  logic [7:0] fault_q, fault_d, ctrl_q, ctrl_d, stat_q, stat_d;
  logic       diag_q, diag_d;
  logic [7:0] cause;
  assign cause = {fev_s, 2'b00};
  // latched faults: events set, reading clears only gone causes
  always_comb begin
    fault_d = fault_q;
    if (rd && ptr == afc_pkg::OFS_FAULT) fault_d = 8'h00;
    fault_d = fault_d | cause;  // set wins over clear
    ctrl_d = ctrl_q;
    if (wr && ptr == afc_pkg::OFS_CONTROL) ctrl_d = wdata;
  end

  // mode selection and diagnostic sequencing
  afc_pkg::afc_mode_t mode_d, mode_q;
  logic any_fault, short_res;
  assign any_fault = |fev_s;
  assign short_res = |dev_s[3:0] & ~dev_s[afc_pkg::SB_OPEN] | dev_s[3]
                     | dev_s[1] | dev_s[0];
  always_comb begin
    diag_d = diag_q;
    if (!stby_s) diag_d = 1'b1;
    else if (ddone_s) diag_d = short_res; // rerun on short
    if (!stby_s) mode_d = afc_pkg::AFC_MODE_STANDBY;
    else if (diag_q) mode_d = afc_pkg::AFC_MODE_DIAG;
    else if (any_fault) mode_d = afc_pkg::AFC_MODE_FAULT;
    else if (mute_s) mode_d = afc_pkg::AFC_MODE_FAULT;
    else mode_d = afc_pkg::AFC_MODE_PLAY;
    stat_d = afc_pkg::STATUS_RST;
    stat_d[3:0] = dev_s;
    stat_d[afc_pkg::SB_FAULT] = mode_d == afc_pkg::AFC_MODE_FAULT && any_fault;
    stat_d[afc_pkg::SB_DIAG]  = mode_d == afc_pkg::AFC_MODE_DIAG;
    stat_d[afc_pkg::SB_MUTE]  = mode_d == afc_pkg::AFC_MODE_FAULT && !any_fault;
    stat_d[afc_pkg::SB_PLAY]  = mode_d == afc_pkg::AFC_MODE_PLAY;
  end

  // read data mux
  always_comb begin
    unique case (ptr)
      afc_pkg::OFS_FAULT:   rdata = fault_q;
      afc_pkg::OFS_STATUS:  rdata = stat_q;
      afc_pkg::OFS_CONTROL: rdata = ctrl_q;
      default:              rdata = 8'h00;
    endcase
  end

  logic rerun_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fault_q <= afc_pkg::FAULT_RST;
      ctrl_q  <= afc_pkg::CONTROL_RST;
      stat_q  <= afc_pkg::STATUS_RST;
      diag_q  <= 1'b0;
      mode_q  <= afc_pkg::AFC_MODE_STANDBY;
      rerun_q <= 1'b0;
    end else if (en_i) begin
      fault_q <= stby_s ? fault_d : afc_pkg::FAULT_RST;
      ctrl_q  <= stby_s ? ctrl_d : afc_pkg::CONTROL_RST;
      stat_q  <= stat_d;
      diag_q  <= diag_d;
      mode_q  <= mode_d;
      rerun_q <= ddone_s & short_res;
    end
  end

  // output registers
  logic flt_q, flo_q, sdaoe_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flt_q <= 1'b0; flo_q <= 1'b1; sdaoe_q <= 1'b0;
    end else if (en_i) begin
      flt_q   <= any_fault | (diag_q & short_res);
      // a shorted result floats the output even while diagnosing
      flo_q   <= mode_d != afc_pkg::AFC_MODE_PLAY &&
                 (mode_d != afc_pkg::AFC_MODE_DIAG || short_res);
      sdaoe_q <= oe_bus;
    end
  end
  assign sda_o        = 1'b0;
  assign sda_oe_o     = sdaoe_q;
  assign fault_n_o    = 1'b0;
  assign fault_n_oe_o = flt_q;
  assign mode_o       = mode_q;
  assign float_o      = flo_q;
  assign rerun_diag_o = rerun_q;
  assign gain_o       = ctrl_q[7:6];
  assign limit_o      = ctrl_q[5:3];
  assign freq_500k_o  = ctrl_q[afc_pkg::CB_FREQ];

  ctrl_reset_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !stby_s && en_i |=> ctrl_q == afc_pkg::CONTROL_RST)
    else $error("control not reset in standby");
  fault_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    en_i && stby_s && fev_s[5] |=> fault_q[7])
    else $error("overtemperature bit not set");
  fault_sticky_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    en_i && stby_s && fault_q[3] && !(rd && ptr == afc_pkg::OFS_FAULT)
    |=> fault_q[3])
    else $error("fault bit lost without read");
  play_float_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    mode_q == afc_pkg::AFC_MODE_PLAY |-> !float_o)
    else $error("output floating in play");
  standby_bus_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    !stby_s && en_i |-> ##2 !sda_oe_o)
    else $error("bus driven in standby");
  fault_pin_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    en_i && any_fault |=> fault_n_oe_o)
    else $error("fault pin not asserted");
  status_mode_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    en_i |=> $onehot0(stat_q[7:4]))
    else $error("status mode flags not exclusive");
  reserved_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    fault_q[1:0] == 2'b00)
    else $error("reserved fault bits set");
endmodule : afc_regs
`default_nettype wire

// ---- design/afc_sync.sv ----
// two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/10ps
`default_nettype none
module afc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic         en_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  // first stage feeds only the second
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= '0;
      s2_q <= '0;
    end else if (en_i) begin
      s1_q <= d_i;
      s2_q <= s1_q;
    end
  end
  assign q_o = s2_q;
endmodule : afc_sync
`default_nettype wire
